// ---- hdl/frtap_fault_record.sv ----
// fault classification, correctable fault record and local memory access policy
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [RULE_01] record every correctable fault location
// [RULE_02] record coherency port cache lookup faults
// [RULE_03] one register, access type and unit
// [RULE_04] newest fault overwrites whole record
// [RULE_05] protection denial gives synchronous protection abort
// [RULE_06] bus load error aborts synchronously
// [RULE_07] bus store error aborts asynchronously (code aborts strongly ordered stores synchronously)
// [RULE_08] cache loads sync; stores, maintenance async
// [RULE_09] local memory ECC aborts synchronously
// [RULE_10] local memory external errors unrecoverable
// [RULE_11] only correctable or retry are recoverable
// [RULE_12] write recoverable flag to auxiliary status
// [RULE_13] correctable error event output provided
// [RULE_14] debug halt: correct, no retry, sticky
// [RULE_15] ignore errors on speculative accesses (code ignores only local memory errors; bus and cache errors still abort)
// [RULE_16] memory A one port, B one/two
// [RULE_17] permission check, attributes not exported
// [RULE_18] denied read issued, abort before use
// [RULE_19] local memory always non-cacheable normal
// [RULE_20] device regions only enforce execute-never
// [RULE_21] prefetch reads only; others read/write
// [RULE_22] software keeps base ranges apart
// [RULE_23] attached memory tolerates repeated accesses
// [RULE_24] external retry reissues the read
// [RULE_25] disabled port ignores external errors
// [RULE_26] event pulses with record update
module frtap_fault_record #(
    parameter int MEMB_PORTS = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // correctable fault report
    input wire logic corrValid,
    input wire frtap_pkg::frtap_acc_t corrAcc,
    input wire frtap_pkg::frtap_unit_t corrUnit,
    input wire logic [23:0] corrAddr,
    // core access under test
    input wire logic accValid,
    input wire logic accFetch,
    input wire logic accSlave,
    input wire logic accWrite,
    input wire logic accSpec,
    input wire logic accLocal,
    input wire logic [1:0] accPort,
    input wire logic accStrongOrd,
    input wire logic accDenied,
    input wire logic debugHalt,
    // error sources for the access
    input wire logic busErr,
    input wire logic cacheErr,
    input wire logic cacheMaint,
    input wire logic cacheErrCorr,
    input wire logic lmEccErr,
    input wire logic lmEccCorr,
    input wire logic [2:0] lmExtErr,
    input wire logic [2:0] lmExtRetry,
    // local memory port request
    output logic lmReq,
    output logic lmWrite,
    // results
    output logic abortSync,
    output logic abortAsync,
    output frtap_pkg::frtap_abort_t abortClass,
    output logic abortRecov,
    output logic retryRead,
    output logic holdData,
    output logic corrEvent
);
    import frtap_pkg::*;

    // ************************************************
    // registers
    // ************************************************
    logic [31:0] corrLoc;
    logic [31:0] ctrl;
    logic [31:0] afsrInstr;
    logic [31:0] afsrData;
    logic dbgSyncSticky;
    logic asyncSeen;

    // ************************************************
    // decode helpers
    // ************************************************
    // port enable bit; port 2 only exists with two B ports
    function automatic logic portEnabled(input logic [31:0] c, input logic [1:0] p);
        logic en;
        en = 1'b0;
        case (p)
            2'h0: en = c[CTRL_ERR_EN_A];
            2'h1: en = c[CTRL_ERR_EN_B0];
            2'h2: en = c[CTRL_ERR_EN_B1] && (MEMB_PORTS == 2);
            default: en = 1'b0;
        endcase
        return en;
    endfunction

    // ************************************************
    // access policy
    // ************************************************
    logic illegalWrite;
    logic xnFault;
    logic permFault;
    logic extErr;
    logic extRetry;
    logic lmErrUse;
    logic portOk;

    always_comb begin
        // [RULE_16] port count check
        portOk = (accPort == 2'h0) || (accPort == 2'h1) || (accPort == 2'h2 && MEMB_PORTS == 2);
        // [RULE_21] prefetch never writes
        illegalWrite = accLocal && accFetch && accWrite;
        // [RULE_20] only execute-never applies
        xnFault = accLocal && accFetch && accStrongOrd;
        // [RULE_17] protection check of core accesses
        permFault = accDenied && !accSlave;
        // [RULE_15] speculative local memory errors dropped
        lmErrUse = accLocal && !accSpec && portOk;
        // [RULE_25] per-port external error enable
        extErr = lmErrUse && lmExtErr[accPort] && portEnabled(ctrl, accPort);
        extRetry = lmErrUse && lmExtRetry[accPort] && !accWrite && !accSlave && portEnabled(ctrl, accPort);
    end

    // ************************************************
    // local memory request
    // ************************************************
    // [RULE_19] no attributes leave the block: always non-cacheable normal
    // [RULE_18] denied reads still go out on the port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lmReq <= 1'b0;
            lmWrite <= 1'b0;
        end else begin
            lmReq <= accValid && accLocal && portOk && !illegalWrite && !(accWrite && permFault);
            lmWrite <= accValid && accLocal && accWrite && !illegalWrite && !permFault;
        end
    end

    // ************************************************
    // abort classification
    // ************************************************
    frtap_abort_t next_class;
    logic next_sync;
    logic next_async;
    logic next_recov;
    logic next_retry;
    logic [2:0] next_src;
    logic corrDbg;

    always_comb begin
        next_class = FRTAP_AB_NONE;
        next_sync = 1'b0;
        next_async = 1'b0;
        next_recov = 1'b0;
        next_retry = 1'b0;
        next_src = SRC_CACHE;
        // [RULE_14] debug halt turns a corrected error into a failure
        corrDbg = debugHalt && ((lmEccErr && lmEccCorr && lmErrUse) || (cacheErr && cacheErrCorr));
        if (!accValid) begin
            next_class = FRTAP_AB_NONE;
        end else if (permFault || xnFault || illegalWrite) begin
            // [RULE_05] protection fault, synchronous
            next_class = FRTAP_AB_PROT;
            next_sync = 1'b1;
            next_src = SRC_PROT;
        end else if (extRetry && !debugHalt) begin
            // [RULE_24] reissue instead of aborting
            next_retry = 1'b1;
            // [RULE_11] a retry request is recoverable
            next_recov = 1'b1;
        end else if (extErr) begin
            // [RULE_10] external memory errors never recoverable
            next_class = FRTAP_AB_LMEXT;
            next_sync = !accWrite;
            next_async = accWrite;
            next_recov = 1'b0;
            next_src = (accPort == 2'h0) ? SRC_MEMA : SRC_MEMB;
        end else if (lmEccErr && lmErrUse && (!lmEccCorr || debugHalt)) begin
            // [RULE_09] loads and stores both synchronous
            next_class = FRTAP_AB_LMECC;
            next_sync = 1'b1;
            // [RULE_11] correctable errors are recoverable
            next_recov = lmEccCorr;
            next_src = (accPort == 2'h0) ? SRC_MEMA : SRC_MEMB;
        end else if (lmEccErr && lmEccCorr && lmErrUse && !accSlave) begin
            // corrected inline, retry the read for the fixed data
            next_retry = 1'b1;
            next_recov = 1'b1;
        end else if (cacheErr && (!cacheErrCorr || debugHalt)) begin
            // [RULE_08] loads sync, stores and maintenance async
            next_class = FRTAP_AB_CACHE;
            next_sync = !accWrite && !cacheMaint;
            next_async = accWrite || cacheMaint;
            next_recov = cacheErrCorr;
        end else if (busErr) begin
            // [RULE_06] load error synchronous
            // [RULE_07] store error asynchronous unless strongly ordered
            next_class = FRTAP_AB_EXT;
            next_sync = !accWrite || accStrongOrd;
            next_async = accWrite && !accStrongOrd;
            next_src = SRC_BUS;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            abortSync <= 1'b0;
            abortAsync <= 1'b0;
            abortClass <= FRTAP_AB_NONE;
            abortRecov <= 1'b0;
            retryRead <= 1'b0;
            holdData <= 1'b0;
        end else begin
            abortSync <= next_sync;
            abortAsync <= next_async;
            abortClass <= next_class;
            abortRecov <= next_recov;
            retryRead <= next_retry;
            // [RULE_18] denied read data is never consumed
            holdData <= accValid && (next_sync || next_retry);
        end
    end

    // ************************************************
    // auxiliary fault status
    // ************************************************
    logic lmAbort;
    assign lmAbort = (next_class == FRTAP_AB_LMEXT) || (next_class == FRTAP_AB_LMECC);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            afsrInstr <= 32'h0000_0000;
            afsrData <= 32'h0000_0000;
        end else if (next_class != FRTAP_AB_NONE) begin
            // [RULE_12] recoverable flag into matching status register
            if (accFetch) begin
                afsrInstr <= {6'h00, next_sync, next_src, lmAbort && next_recov, 21'h000000};
            end else begin
                afsrData <= {6'h00, next_sync, next_src, lmAbort && next_recov, 21'h000000};
            end
        end
    end

    // ************************************************
    // correctable fault record
    // ************************************************
    // [RULE_01] every correctable fault, abort or not
    // [RULE_02] coherency lookups arrive as FRTAP_ACC_COHER
    // [RULE_03] shared register with type and unit
    // [RULE_04] whole record replaced each time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            corrLoc <= 32'h0000_0000;
        end else if (corrValid) begin
            corrLoc <= {1'b1, 1'b0, corrAcc, corrUnit, 2'b00, corrAddr[LOC_ADDR_W-1:0]};
        end
    end

    // [RULE_13] event output for an interrupt controller
    // [RULE_26] pulse in the update cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            corrEvent <= 1'b0;
        end else begin
            corrEvent <= corrValid;
        end
    end

    // ************************************************
    // status and control
    // ************************************************
    logic clearWr;
    assign clearWr = regWrite && (regAddr == ADDR_CLEAR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (regWrite && regAddr == ADDR_CTRL) begin
            ctrl <= {29'h0000000, regWdata[2:0]};
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dbgSyncSticky <= 1'b0;
            asyncSeen <= 1'b0;
        end else begin
            // [RULE_14] sticky synchronous abort in debug halt
            if (accValid && corrDbg) begin
                dbgSyncSticky <= 1'b1;
            end else if (clearWr && regWdata[STAT_DBG_SYNC]) begin
                dbgSyncSticky <= 1'b0;
            end
            if (next_async) begin
                asyncSeen <= 1'b1;
            end else if (clearWr && regWdata[STAT_ASYNC]) begin
                asyncSeen <= 1'b0;
            end
        end
    end

    // ************************************************
    // register read
    // ************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                ADDR_CORRECTABLE_FAULT_LOCATION_REG: regRdata <= corrLoc;
                ADDR_CTRL: regRdata <= ctrl;
                ADDR_AFSR_INSTR: regRdata <= afsrInstr;
                ADDR_AFSR_DATA: regRdata <= afsrData;
                ADDR_STATUS: regRdata <= {30'h00000000, asyncSeen, dbgSyncSticky};
                default: regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end
endmodule

`default_nettype wire

// ---- pkg/frtap_pkg.sv ----
// shared constants and types for the fault record and local memory policy block
package frtap_pkg;
    // register map (plain port, byte offsets)
    localparam logic [7:0] ADDR_CORRECTABLE_FAULT_LOCATION_REG = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_AFSR_INSTR = 8'h08;
    localparam logic [7:0] ADDR_AFSR_DATA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CLEAR = 8'h14;
    // control register fields
    localparam int CTRL_ERR_EN_A = 0;
    localparam int CTRL_ERR_EN_B0 = 1;
    localparam int CTRL_ERR_EN_B1 = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // location register fields
    localparam int LOC_VALID = 31;
    localparam int LOC_TYPE_LSB = 28;
    localparam int LOC_UNIT_LSB = 26;
    localparam int LOC_ADDR_W = 24;
    // auxiliary fault status fields
    localparam int AFSR_RECOV = 21;
    localparam int AFSR_SRC_LSB = 22;
    localparam int AFSR_SYNC = 25;
    // status fields
    localparam int STAT_DBG_SYNC = 0;
    localparam int STAT_ASYNC = 1;
    // access type of a correctable fault
    typedef enum logic [1:0] {
        FRTAP_ACC_FETCH = 2'h0,
        FRTAP_ACC_DATA = 2'h1,
        FRTAP_ACC_SLAVE = 2'h2,
        FRTAP_ACC_COHER = 2'h3
    } frtap_acc_t;
    // memory unit holding the fault
    typedef enum logic [1:0] {
        FRTAP_UNIT_MEMA = 2'h0,
        FRTAP_UNIT_MEMB = 2'h1,
        FRTAP_UNIT_CACHE = 2'h2
    } frtap_unit_t;
    // abort class reported to the core
    typedef enum logic [2:0] {
        FRTAP_AB_NONE = 3'h0,
        FRTAP_AB_PROT = 3'h1,
        FRTAP_AB_EXT = 3'h2,
        FRTAP_AB_CACHE = 3'h3,
        FRTAP_AB_LMECC = 3'h4,
        FRTAP_AB_LMEXT = 3'h5
    } frtap_abort_t;
    // auxiliary status source codes
    localparam logic [2:0] SRC_CACHE = 3'h0;
    localparam logic [2:0] SRC_BUS = 3'h1;
    localparam logic [2:0] SRC_MEMA = 3'h2;
    localparam logic [2:0] SRC_MEMB = 3'h3;
    localparam logic [2:0] SRC_PROT = 3'h4;
endpackage

// ---- sim/frtap_fault_record_assertions.sv ----
// checker tying fault record outputs to their causes
`timescale 1ns/100ps
`default_nettype none
// ****
// output relations
// ****
module frtap_fault_record_checker
    import frtap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // causes
    input wire logic corrValid,
    input wire logic accValid,
    input wire logic accFetch,
    input wire logic accWrite,
    input wire logic accSpec,
    input wire logic accLocal,
    input wire logic accStrongOrd,
    input wire logic accDenied,
    input wire logic debugHalt,
    input wire logic busErr,
    input wire logic cacheErr,
    input wire logic lmEccErr,
    input wire logic lmEccCorr,
    input wire logic [2:0] lmExtErr,
    input wire logic [2:0] lmExtRetry,
    // effects
    input wire logic lmReq,
    input wire logic lmWrite,
    input wire logic abortSync,
    input wire logic abortAsync,
    input wire frtap_pkg::frtap_abort_t abortClass,
    input wire logic retryRead,
    input wire logic holdData,
    input wire logic corrEvent
);
    logic quiet;
    // higher priority causes absent
    assign quiet = !accDenied && !accFetch && lmExtErr == 3'h0 && lmExtRetry == 3'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_denRd;
        accValid && accLocal && accDenied && !accWrite;
    endsequence
    sequence s_busSt;
        accValid && busErr && accWrite && !accStrongOrd && !accLocal && !cacheErr && quiet;
    endsequence
    property p_evt;
        corrValid |=> corrEvent;
    endproperty
    a_evt: assert property (p_evt) else $error("no event after fault");
    property p_prot;
        accValid && accDenied |=> abortSync && abortClass == FRTAP_AB_PROT;
    endproperty
    a_prot: assert property (p_prot) else $error("denial not aborted");
    property p_den;
        s_denRd |=> lmReq && holdData && abortSync;
    endproperty
    a_den: assert property (p_den) else $error("denied read misuse");
    property p_xn;
        accValid && accLocal && accFetch && accStrongOrd |=> abortSync && abortClass == FRTAP_AB_PROT;
    endproperty
    a_xn: assert property (p_xn) else $error("fetch from device region");
    property p_pfw;
        accValid && accLocal && accFetch && accWrite |=> !lmWrite && abortSync;
    endproperty
    a_pfw: assert property (p_pfw) else $error("prefetch write passed");
    property p_busld;
        accValid && busErr && !accWrite && !accLocal && !cacheErr && quiet |=> abortSync && abortClass == FRTAP_AB_EXT;
    endproperty
    a_busld: assert property (p_busld) else $error("bus load error class");
    property p_busst;
        s_busSt |=> abortAsync && !abortSync;
    endproperty
    a_busst: assert property (p_busst) else $error("bus store not async");
    property p_ecc;
        accValid && accLocal && !accSpec && lmEccErr && !lmEccCorr && quiet |=> abortSync && abortClass == FRTAP_AB_LMECC;
    endproperty
    a_ecc: assert property (p_ecc) else $error("local ecc not sync");
    property p_spec;
        accValid && accSpec && !accDenied && !accFetch && !busErr && !cacheErr && !lmEccErr |=> !abortSync && !abortAsync && !retryRead;
    endproperty
    a_spec: assert property (p_spec) else $error("speculative error used");
    property p_halt;
        accValid && debugHalt && accLocal && !accSpec && lmEccErr && lmEccCorr && quiet |=> abortSync && !retryRead;
    endproperty
    a_halt: assert property (p_halt) else $error("halt retried access");
endmodule
bind frtap_fault_record frtap_fault_record_checker u_chk (.*);
`default_nettype wire

// ---- sim/frtap_fault_record_bench.sv ----
// self-checking bench for the fault record block
`timescale 1ns/100ps
`default_nettype none
// ****
// bench
// ****
module frtap_fault_record_bench;
    import frtap_pkg::*;
    logic clk, rst, regWrite, regRead, corrValid, accValid, errOn, rtyOn;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [23:0] corrAddr;
    frtap_acc_t corrAcc;
    frtap_unit_t corrUnit;
    frtap_abort_t abortClass;
    logic accFetch, accSlave, accWrite, accSpec, accLocal, accStrongOrd, accDenied, debugHalt;
    logic busErr, cacheErr, cacheMaint, cacheErrCorr, lmEccErr, lmEccCorr;
    logic [1:0] accPort;
    logic [2:0] lmExtErr, lmExtRetry;
    logic lmReq, lmWrite, abortSync, abortAsync, abortRecov, retryRead, holdData, corrEvent;
    int err_count, check_count;
    frtap_fault_record #(.MEMB_PORTS(2)) u_dut (.*);
    frtap_lm_model u_lm (.*);
    always #5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdata, x);
    endtask
    task corr(input int i, input logic [23:0] a);
        @(posedge clk);
        corrValid <= 1'b1;
        corrAcc <= frtap_acc_t'(i[1:0]);
        corrUnit <= frtap_unit_t'(2'(i % 3));
        corrAddr <= a;
        @(posedge clk);
        corrValid <= 1'b0;
        #1 chk({31'h0, corrEvent}, 32'h1);
    endtask
    // flags: fetch slave write spec local strong denied halt bus cerr maint ccorr ecc ecor
    task acc(input logic [13:0] f, input logic [1:0] p, input logic [1:0] e, input logic [6:0] x);
        @(posedge clk);
        accValid <= 1'b1;
        {accFetch, accSlave, accWrite, accSpec, accLocal, accStrongOrd, accDenied} <= f[13:7];
        {debugHalt, busErr, cacheErr, cacheMaint, cacheErrCorr, lmEccErr, lmEccCorr} <= f[6:0];
        accPort <= p;
        {errOn, rtyOn} <= e;
        @(posedge clk);
        accValid <= 1'b0;
        #1 chk({25'h0, abortSync, abortAsync, abortClass, abortRecov, retryRead}, {25'h0, x});
    endtask
    task wrap_up;
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        wrap_up;
    end
    initial begin
        {clk, regWrite, regRead, corrValid, accValid, errOn, rtyOn, regAddr, regWdata, corrAddr} = '0;
        {accFetch, accSlave, accWrite, accSpec, accLocal, accStrongOrd, accDenied, accPort} = '0;
        {debugHalt, busErr, cacheErr, cacheMaint, cacheErrCorr, lmEccErr, lmEccCorr} = '0;
        corrAcc = FRTAP_ACC_FETCH;
        corrUnit = FRTAP_UNIT_MEMA;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        wr(ADDR_CTRL, 32'h3);
        rd(ADDR_CTRL, 32'h3);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 4; i++) begin
            corr(i, (i < 3) ? 24'hffffff : 24'h000012);
        end
        rd(ADDR_CORRECTABLE_FAULT_LOCATION_REG, (32'h1 << LOC_VALID) | (32'h3 << LOC_TYPE_LSB) | 32'h12);
        acc(14'b00001010000000, 2'h0, 2'b00, 7'b1000100);
        acc(14'b00000000100000, 2'h0, 2'b00, 7'b1001000);
        acc(14'b00100000100000, 2'h0, 2'b00, 7'b0101000);
        acc(14'b00000000010000, 2'h0, 2'b00, 7'b1001100);
        acc(14'b00100000010000, 2'h0, 2'b00, 7'b0101100);
        acc(14'b00000000011000, 2'h0, 2'b00, 7'b0101100);
        acc(14'b00001000000010, 2'h0, 2'b00, 7'b1010000);
        acc(14'b00101000000010, 2'h1, 2'b00, 7'b1010000);
        acc(14'b00001000000011, 2'h0, 2'b00, 7'b0000011);
        acc(14'b00001000000000, 2'h0, 2'b10, 7'b1010100);
        rd(ADDR_AFSR_DATA, (32'h1 << AFSR_SYNC) | (32'(SRC_MEMA) << AFSR_SRC_LSB));
        acc(14'b00101000000000, 2'h1, 2'b10, 7'b0110100);
        acc(14'b00011000000000, 2'h0, 2'b10, 7'b0000000);
        acc(14'b00001000000000, 2'h1, 2'b01, 7'b0000011);
        acc(14'b00001000000000, 2'h2, 2'b10, 7'b0000000);
        acc(14'b10001100000000, 2'h0, 2'b00, 7'b1000100);
        acc(14'b10101000000000, 2'h0, 2'b00, 7'b1000100);
        acc(14'b01101000000000, 2'h1, 2'b00, 7'b0000000);
        acc(14'b00001001000011, 2'h0, 2'b00, 7'b1010010);
        rd(ADDR_AFSR_DATA, (32'h1 << AFSR_SYNC) | (32'(SRC_MEMA) << AFSR_SRC_LSB) | (32'h1 << AFSR_RECOV));
        rd(ADDR_STATUS, 32'h3);
        wr(ADDR_CLEAR, 32'h3);
        rd(ADDR_STATUS, 32'h0);
        wrap_up;
    end
endmodule
`default_nettype wire

// ---- sim/frtap_lm_model.sv ----
// far side model: local memory controller error lines
`timescale 1ns/100ps
`default_nettype none
// ****
// error and retry signalling
// ****
module frtap_lm_model (
    // access seen by the memory
    input wire logic accValid,
    input wire logic accWrite,
    input wire logic [1:0] accPort,
    // scenario controls
    input wire logic errOn,
    input wire logic rtyOn,
    // lines to the core
    output logic [2:0] lmExtErr,
    output logic [2:0] lmExtRetry
);
    // each access names one port, ranges kept apart
    // stateless, repeats alike
    // only the addressed port flags an error
    assign lmExtErr = (accValid && errOn) ? 3'h1 << accPort : 3'h0;
    assign lmExtRetry = (accValid && rtyOn && !accWrite) ? 3'h1 << accPort : 3'h0;
endmodule
`default_nettype wire
